// ==== rtl/scw_bank.v ====
`timescale 1ns/1ps
`include "scw_map.vh"
module scw_bank #(
	parameter SETTLE_CYC = `SCW_SETTLE_CYC
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rstn,
	// serial port pins
	input  wire        ser_clk,
	input  wire        ser_data,
	input  wire        latch_strobe,
	// analog side status
	input  wire        pump_pulse_active,
	input  wire        digital_lock,
	input  wire        analog_lock_n,
	input  wire        ref_div_out,
	input  wire        fb_div_out,
	// decoded controls
	output reg  [9:0]  ref_divide_ratio,
	output reg         pump_float,
	output reg         detector_polarity,
	output reg  [1:0]  lock_pin_select,
	output reg  [2:0]  ref_buffer_tune,
	output reg  [1:0]  power_mode,
	output reg  [4:0]  swallow_count,
	output reg  [9:0]  main_count,
	// derived state
	output reg         powered_down,
	output reg         dividers_hold,
	// lock pin
	output reg         lock_pin_o,
	output reg         lock_pin_oe
);
	wire [2:0] pins_s;
	scw_sync #(.W(3)) u_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.async_in ({ser_clk, ser_data, latch_strobe}),
		.sync_out (pins_s)
	);
	wire sclk_s = pins_s[2];
	wire sdat_s = pins_s[1];
	wire le_s   = pins_s[0];

	reg                     sclk_prev_q;
	reg                     le_prev_q;
	reg [`SCW_SHIFT_W-1:0]  shift_q;
	reg [`SCW_WORD_W-1:0]   ref_word_q;
	reg [`SCW_WORD_W-1:0]   fb_word_q;
	reg                     pump_seen_q;
	reg [15:0]              settle_q;

	wire sclk_rise = sclk_s & ~sclk_prev_q;
	wire le_rise   = le_s & ~le_prev_q;

	// serial shift and word latching
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_q <= 1'b0;
			le_prev_q   <= 1'b0;
			shift_q     <= {`SCW_SHIFT_W{1'b0}};
			ref_word_q  <= {`SCW_WORD_W{1'b0}};
			fb_word_q   <= {`SCW_WORD_W{1'b0}};
		end else begin
			sclk_prev_q <= sclk_s;
			le_prev_q   <= le_s;
			if (sclk_rise) begin
				shift_q <= {shift_q[`SCW_SHIFT_W-2:0], sdat_s};
			end
			if (le_rise) begin
				if (shift_q[`SCW_ADDR_BIT] == `SCW_ADDR_REF) begin
					ref_word_q <= shift_q[`SCW_SHIFT_W-1:1];
				end else begin
					fb_word_q <= shift_q[`SCW_SHIFT_W-1:1];
				end
			end
		end
	end

	// padded word bit n sits at shift bit n, so field indices are shift bit positions
	wire [`SCW_SHIFT_W-1:0] rw = {ref_word_q, 1'b1};
	wire [`SCW_SHIFT_W-1:0] fw = {fb_word_q, 1'b0};
	wire [1:0] pm_w = fw[`SCW_PMODE_HI:`SCW_PMODE_LO];

	// power state: sync power-down waits for the end of a pump pulse
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pump_seen_q   <= 1'b0;
			powered_down  <= 1'b0;
			dividers_hold <= 1'b0;
			settle_q      <= 16'h0000;
		end else begin
			pump_seen_q <= pump_pulse_active;
			case (pm_w)
				`SCW_PM_NORMAL: begin
					if (powered_down) begin
						powered_down  <= 1'b0;
						dividers_hold <= 1'b1;
						settle_q      <= SETTLE_CYC[15:0];
					end else if (settle_q > 16'h0001) begin
						settle_q <= settle_q - 16'h0001;
					end else begin
						settle_q      <= 16'h0000;
						dividers_hold <= 1'b0;
					end
				end
				`SCW_PM_SYNC_PD: begin
					if (pump_seen_q & ~pump_pulse_active) begin
						powered_down  <= 1'b1;
						dividers_hold <= 1'b1;
					end
				end
				`SCW_PM_CNT_RST: begin
					dividers_hold <= 1'b1;
					settle_q      <= 16'h0000;
				end
				default: begin
					powered_down  <= 1'b1;
					dividers_hold <= 1'b1;
				end
			endcase
		end
	end

	// field decode and lock pin drive
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ref_divide_ratio  <= 10'h000;
			pump_float        <= 1'b0;
			detector_polarity <= 1'b0;
			lock_pin_select   <= 2'h0;
			ref_buffer_tune   <= 3'h0;
			power_mode        <= 2'h0;
			swallow_count     <= 5'h00;
			main_count        <= 10'h000;
			lock_pin_o        <= 1'b0;
			lock_pin_oe       <= 1'b0;
		end else begin
			ref_divide_ratio  <= rw[`SCW_RDIV_HI:`SCW_RDIV_LO];
			pump_float        <= rw[`SCW_FLOAT_BIT];
			detector_polarity <= rw[`SCW_POL_BIT];
			lock_pin_select   <= rw[`SCW_LSEL_HI:`SCW_LSEL_LO];
			ref_buffer_tune   <= rw[`SCW_TUNE_HI:`SCW_TUNE_LO];
			power_mode        <= pm_w;
			swallow_count     <= fw[`SCW_SWAL_HI:`SCW_SWAL_LO];
			main_count        <= fw[`SCW_MAIN_HI:`SCW_MAIN_LO];
			if (powered_down) begin
				lock_pin_o  <= 1'b0;
				lock_pin_oe <= 1'b0;
			end else begin
				case (rw[`SCW_LSEL_HI:`SCW_LSEL_LO])
					`SCW_LS_DIGITAL: begin
						lock_pin_o  <= digital_lock;
						lock_pin_oe <= 1'b1;
					end
					`SCW_LS_ANALOG: begin
						lock_pin_o  <= 1'b0;
						lock_pin_oe <= ~analog_lock_n;
					end
					`SCW_LS_REFDIV: begin
						lock_pin_o  <= ref_div_out;
						lock_pin_oe <= 1'b1;
					end
					default: begin
						lock_pin_o  <= fb_div_out;
						lock_pin_oe <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule

// ==== rtl/scw_map.vh ====
`ifndef SCW_MAP_VH
`define SCW_MAP_VH
`define SCW_SHIFT_W      18
`define SCW_WORD_W       17
`define SCW_ADDR_BIT     0
`define SCW_ADDR_REF     1'b1
`define SCW_RDIV_HI      10
`define SCW_RDIV_LO      1
`define SCW_FLOAT_BIT    11
`define SCW_POL_BIT      12
`define SCW_LSEL_HI      14
`define SCW_LSEL_LO      13
`define SCW_TUNE_HI      17
`define SCW_TUNE_LO      15
`define SCW_PMODE_HI     2
`define SCW_PMODE_LO     1
`define SCW_SWAL_HI      7
`define SCW_SWAL_LO      3
`define SCW_MAIN_HI      17
`define SCW_MAIN_LO      8
`define SCW_PM_NORMAL    2'h0
`define SCW_PM_SYNC_PD   2'h1
`define SCW_PM_CNT_RST   2'h2
`define SCW_PM_ASYNC_PD  2'h3
`define SCW_LS_DIGITAL   2'h0
`define SCW_LS_ANALOG    2'h1
`define SCW_LS_REFDIV    2'h2
`define SCW_LS_FBDIV     2'h3
`define SCW_SETTLE_NS    1500
`define SCW_CLK_NS       10
`define SCW_SETTLE_CYC   ((`SCW_SETTLE_NS + `SCW_CLK_NS - 1) / `SCW_CLK_NS)
`endif

// ==== rtl/scw_sync.v ====
`timescale 1ns/1ps
// two-flop synchroniser per bit
module scw_sync #(
	parameter W = 3
) (
	// clock and reset
	input  wire         clk_sys,
	input  wire         rstn,
	// data
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule

// ==== test/scw_bank_checker.sv ====
`timescale 1ns/1ps
module scw_bank_checker (
	input       clk_sys, rstn, ser_clk, ser_data, latch_strobe, pump_pulse_active,
	input [9:0] ref_divide_ratio, main_count,
	input [4:0] swallow_count,
	input [2:0] ref_buffer_tune,
	input [1:0] lock_pin_select, power_mode,
	input       pump_float, detector_polarity, powered_down, dividers_hold, lock_pin_o,
	input       lock_pin_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [17:0] sh_q;
	logic [7:0]  ls_q;
	logic        sc_q;
	wire  [16:0] rw = {ref_buffer_tune, lock_pin_select, detector_polarity, pump_float,
		ref_divide_ratio};
	wire  [16:0] fw = {main_count, swallow_count, power_mode};
	// mirror of the serial shift register
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{sh_q, ls_q, sc_q} <= 27'h0;
		end else begin
			sc_q <= ser_clk;
			ls_q <= {ls_q[6:0], latch_strobe};
			if (ser_clk && !sc_q) sh_q <= {sh_q[16:0], ser_data};
		end
	end
	sequence s_latch(b);
		$rose(latch_strobe) && sh_q[0] == b;
	endsequence
	a_ref_load: assert property (s_latch(1'b1) |-> ##[1:8] rw == sh_q[17:1])
		else $error("ref word");
	a_fb_load: assert property (s_latch(1'b0) |-> ##[1:8] fw == sh_q[17:1])
		else $error("fb word");
	a_word_hold: assert property (!$stable({rw, fw}) |-> |ls_q) else $error("drift");
	a_async_pd: assert property (power_mode == 2'h3 |-> ##[0:2] powered_down)
		else $error("async pd");
	a_cnt_rst: assert property (power_mode == 2'h2 |-> ##[0:2] dividers_hold)
		else $error("cnt rst");
	a_sync_gate: assert property ($rose(powered_down) && power_mode == 2'h1
		|-> !pump_pulse_active) else $error("sync pd");
	a_pd_float: assert property (powered_down && $past(powered_down) |-> !lock_pin_oe)
		else $error("pd oe");
	a_up_hold: assert property ($fell(powered_down) |-> ##[0:1] dividers_hold)
		else $error("up hold");
	a_push_pull: assert property (!powered_down && lock_pin_select != 2'h1
		&& $stable(lock_pin_select) |-> ##[0:2] lock_pin_oe) else $error("push");
	a_open_drain: assert property (lock_pin_oe && lock_pin_select == 2'h1
		&& $past(lock_pin_select) == 2'h1 |-> !lock_pin_o) else $error("drain");
endmodule
bind scw_bank scw_bank_checker u_chk (.*);

// ==== test/scw_host.sv ====
`timescale 1ns/1ps
module scw_host (
	input  wire clk_sys,
	output reg  ser_clk,
	output reg  ser_data,
	output reg  latch_strobe
);
	initial {ser_clk, ser_data, latch_strobe} = 3'h0;
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic send(input logic [17:0] w);
		for (int i = 17; i >= 0; i--) begin
			ser_data = w[i];
			wt(4);
			ser_clk = 1'b1;
			wt(8);
			ser_clk = 1'b0;
			wt(4);
		end
		ser_data = ~ser_data;
		latch_strobe = 1'b1;
		wt(8);
		latch_strobe = 1'b0;
	endtask
endmodule

// ==== test/scw_bank_bench.sv ====
`timescale 1ns/1ps
module scw_bank_bench;
	localparam int ST = 40;
	logic clk_sys = 1'b0, rstn = 1'b0, pump_pulse_active = 1'b0;
	logic digital_lock, analog_lock_n, ref_div_out, fb_div_out;
	wire       ser_clk, ser_data, latch_strobe, pump_float, detector_polarity;
	wire [9:0] ref_divide_ratio, main_count;
	wire [4:0] swallow_count;
	wire [2:0] ref_buffer_tune;
	wire [1:0] lock_pin_select, power_mode;
	wire       powered_down, dividers_hold, lock_pin_o, lock_pin_oe;
	wire [16:0] rw = {ref_buffer_tune, lock_pin_select, detector_polarity, pump_float,
		ref_divide_ratio};
	wire [16:0] fw = {main_count, swallow_count, power_mode};
	int n_fail = 0, samples_checked = 0;
	initial forever #5 clk_sys = ~clk_sys;
	scw_host u_host (.*);
	scw_bank #(.SETTLE_CYC(ST)) DUT (.*);
	task automatic chk(input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic t_ref;
		logic [16:0] w;
		for (int k = 0; k < 4; k++) begin
			w = {k[0] ? 3'h7 : 3'h0, 2'(k), k[0], ~k[0], k[0] ? 10'h3ff : 10'h002};
			// lock sources flip between the first two and last two passes so the selected source drives ~k[0]
			{digital_lock, analog_lock_n, ref_div_out, fb_div_out} = k[1] ? 4'h6 : 4'h9;
			u_host.send({w, 1'b1});
			chk(rw, w);
			chk({lock_pin_oe, lock_pin_o}, {1'b1, ~k[0]});
			chk(fw, 17'h0);
		end
		$display("t_ref done");
	endtask
	task automatic t_fb;
		logic [16:0] w;
		for (int k = 0; k < 2; k++) begin
			w = (k != 0) ? 17'h1fff8 : 17'h00300;
			u_host.send({w, 1'b0});
			chk(fw, w);
			chk(rw, 17'h1fbff);
		end
		$display("t_fb done");
	endtask
	task automatic t_pwr;
		int n;
		n = 0;
		u_host.send(18'h00306);
		chk({powered_down, lock_pin_oe}, 2'h2);
		fork
			u_host.send(18'h00300);
			begin
				for (int i = 0; i < 600 && powered_down !== 1'b0; i++) u_host.wt(1);
				while (dividers_hold === 1'b1 && n < 99) begin
					n++;
					u_host.wt(1);
				end
			end
		join
		if (powered_down !== 1'b0) begin
			n_fail++;
			wrap_up;
		end
		chk(n >= ST - 1 && n <= ST + 1, 1);
		u_host.send(18'h00304);
		chk({dividers_hold, powered_down}, 2'h2);
		u_host.send(18'h00300);
		chk(dividers_hold, 1'b0);
		pump_pulse_active = 1'b1;
		u_host.send(18'h00302);
		chk(powered_down, 1'b0);
		pump_pulse_active = 1'b0;
		u_host.wt(6);
		chk(powered_down, 1'b1);
		$display("t_pwr done");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		#1 rstn = 1'b1;
		u_host.wt(3);
		chk({rw, fw}, 34'h0);
		t_ref;
		t_fb;
		t_pwr;
		wrap_up;
	end
endmodule
